/* design/tsw_ack_drv.sv */
// Transfer acknowledge pin driver: low, active high, then released
`timescale 1ns/1ps
`include "tsw_params.svh"
module tsw_ack_drv #(
    parameter int HOLD_NS = `TSW_ACK_HOLD_NS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ack_req,
    input wire logic ack_pin_i,
    output logic transfer_ack_n_o,
    output logic transfer_ack_oe
);
    localparam int HOLD_RAW = HOLD_NS / `TSW_CLK_NS;
    localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    typedef struct packed {
        tsw_pkg::tsw_ack_e st;
        logic [3:0] cnt;
    } tsw_ack_s;
    tsw_ack_s q;
    tsw_ack_s n;
    if (HOLD_CYC > 15) begin : g_bad_hold
        $error("Acknowledge hold too long for counter");
    end
    always_comb begin
        n = q;
        case (q.st)
            tsw_pkg::TSW_ACK_REL: begin
                if (ack_req) begin
                    n.st = tsw_pkg::TSW_ACK_LOW;
                end
            end
            tsw_pkg::TSW_ACK_LOW: begin
                if (!ack_req) begin
                    n.st = tsw_pkg::TSW_ACK_HIGH;
                    n.cnt = 4'h0;
                end
            end
            tsw_pkg::TSW_ACK_HIGH: begin
                // Keep driving high until the wire reads high or HOLD_CYC cycles have passed
                if (ack_req) begin
                    n.st = tsw_pkg::TSW_ACK_LOW;
                end else if (ack_pin_i || q.cnt == 4'(HOLD_CYC - 1)) begin
                    n.st = tsw_pkg::TSW_ACK_REL;
                end else begin
                    n.cnt = q.cnt + 4'h1;
                end
            end
            default: begin
                n.st = tsw_pkg::TSW_ACK_REL;
            end
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: tsw_pkg::TSW_ACK_REL, cnt: 4'h0};
        end else begin
            q <= n;
        end
    end
    assign transfer_ack_n_o = (q.st != tsw_pkg::TSW_ACK_LOW);
    assign transfer_ack_oe = (q.st != tsw_pkg::TSW_ACK_REL);
    property p_ack_low;
        @(posedge clock) disable iff (!rst_n)
        ack_req |=> !transfer_ack_n_o && transfer_ack_oe;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("Acknowledge not driven low");
    property p_ack_release;
        @(posedge clock) disable iff (!rst_n)
        $fell(ack_req) |=> transfer_ack_oe && transfer_ack_n_o
            ##[1:16] !transfer_ack_oe || ack_req;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("Acknowledge not driven high then released");
endmodule : tsw_ack_drv

/* design/tsw_cm_dec.sv */
// Decoder of one connection memory word into per-channel switch controls
`timescale 1ns/1ps
module tsw_cm_dec #(
    parameter int MSG_BIT = 13,
    parameter int DLY_BIT = 12,
    parameter int SIDE_BIT = 12
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] word,
    output logic msg_en,
    output logic [7:0] msg_byte,
    output logic [4:0] src_stream,
    output logic [6:0] src_chan,
    output logic const_delay,
    output logic src_side
);
    typedef struct packed {
        logic msg;
        logic [7:0] byte_v;
        logic [4:0] st;
        logic [6:0] ch;
        logic dly;
        logic side;
    } tsw_dec_s;
    tsw_dec_s q;
    tsw_dec_s n;
    if (MSG_BIT > 15 || DLY_BIT > 15 || SIDE_BIT > 15 || MSG_BIT < 12) begin : g_bad_field
        $error("Field position out of range");
    end
    always_comb begin
        n = q;
        n.msg = word[MSG_BIT];
        n.dly = word[DLY_BIT];
        n.side = word[SIDE_BIT];
        // Message channel drives the low byte, else the source address applies
        n.byte_v = word[MSG_BIT] ? word[7:0] : 8'h00;
        n.st = word[MSG_BIT] ? 5'h00 : word[11:7];
        n.ch = word[MSG_BIT] ? 7'h00 : word[6:0];
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    assign msg_en = q.msg;
    assign msg_byte = q.byte_v;
    assign src_stream = q.st;
    assign src_chan = q.ch;
    assign const_delay = q.dly;
    assign src_side = q.side;
    property p_msg_byte;
        @(posedge clock) disable iff (!rst_n)
        word[MSG_BIT] |=> msg_en && msg_byte == $past(word[7:0]);
    endproperty
    a_msg_byte: assert property (p_msg_byte)
        else $error("Message channel byte not taken from low word bits");
    property p_src_sel;
        @(posedge clock) disable iff (!rst_n)
        !word[MSG_BIT] |=> !msg_en && src_chan == $past(word[6:0])
            && src_stream == $past(word[11:7]);
    endproperty
    a_src_sel: assert property (p_src_sel)
        else $error("Switched source address wrong");
endmodule : tsw_cm_dec

/* design/tsw_conn_ctrl.sv */
// Connection control of a time-slot switch: mode, memories, buffered reads
`timescale 1ns/1ps
`include "tsw_params.svh"
module tsw_conn_ctrl #(
    parameter int BP_STREAMS = 32,
    parameter int BP_CHANS = 64,
    parameter int LOC_STREAMS = 16,
    parameter int LOC_CHANS = 32,
    parameter int READ_LAT = `TSW_READ_LAT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cpu_cs_n,
    input wire logic cpu_ds_n,
    input wire logic cpu_rd,
    input wire logic [11:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    output logic transfer_ack_n_o,
    output logic transfer_ack_oe,
    input wire logic transfer_ack_n_i,
    input wire logic [4:0] bp_out_stream,
    input wire logic [6:0] bp_out_chan,
    input wire logic [4:0] loc_out_stream,
    input wire logic [6:0] loc_out_chan,
    output tsw_pkg::tsw_loc_mode_e local_mode_field,
    output tsw_pkg::tsw_bp_mode_e backplane_mode_field,
    output logic local_mode_valid,
    output logic backplane_mode_valid,
    output logic subrate_en,
    output logic addr_buffer_enable,
    output logic bp_msg_en,
    output logic [7:0] bp_msg_byte,
    output logic [4:0] bp_src_stream,
    output logic [6:0] bp_src_chan,
    output logic bp_const_delay,
    output logic loc_msg_en,
    output logic [7:0] loc_msg_byte,
    output logic [4:0] loc_src_stream,
    output logic [6:0] loc_src_chan,
    output logic loc_const_delay,
    output logic loc_src_backplane,
    output logic [1:0] subrate_bit_position
);
    localparam int BSW = $clog2(BP_STREAMS);
    localparam int BCW = $clog2(BP_CHANS);
    localparam int LSW = $clog2(LOC_STREAMS);
    localparam int LCW = $clog2(LOC_CHANS);
    localparam int BP_DEPTH = BP_STREAMS * BP_CHANS;
    localparam int LOC_DEPTH = LOC_STREAMS * LOC_CHANS;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if ((1 << BSW) != BP_STREAMS || (1 << BCW) != BP_CHANS || BSW > 5 || BCW > 7
        || BSW < 1 || BCW < 1) begin : g_bad_bp_shape
        $error("Backplane memory shape not supported");
    end
    if ((1 << LSW) != LOC_STREAMS || (1 << LCW) != LOC_CHANS || LSW > 5 || LCW > 7
        || LSW < 1 || LCW < 1) begin : g_bad_loc_shape
        $error("Local memory shape not supported");
    end
    if (READ_LAT < 1 || READ_LAT > 8) begin : g_bad_lat
        $error("Read latency must be 1 to 8");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        tsw_pkg::tsw_bus_e bus;
        logic [15:0] ctrl;
        logic [15:0] device_mode_select;
        logic rs;
        logic cda;
        logic [11:0] ab_addr;
        logic [15:0] data_read_reg;
        logic [3:0] lat;
        logic [15:0] rdata;
        logic [1:0] subrate;
        logic [BP_DEPTH-1:0][15:0] bp_cm;
        logic [LOC_DEPTH-1:0][15:0] loc_lo;
        logic [LOC_DEPTH-1:0][15:0] loc_hi;
    } tsw_state_s;
    tsw_state_s q;
    tsw_state_s n;
    function automatic logic [15:0] cm_rd(input tsw_state_s s, input logic [2:0] ms,
                                          input logic [4:0] st, input logic [6:0] ch);
        logic [15:0] w;
        w = 16'h0000;
        if (ms == tsw_pkg::TSW_MS_LOC_LO) begin
            w = s.loc_lo[{st[LSW-1:0], ch[LCW-1:0]}];
        end else if (ms == tsw_pkg::TSW_MS_LOC_HI) begin
            w = s.loc_hi[{st[LSW-1:0], ch[LCW-1:0]}];
        end else if (ms == tsw_pkg::TSW_MS_BP_CM) begin
            w = s.bp_cm[{st[BSW-1:0], ch[BCW-1:0]}];
        end
        return w;
    endfunction : cm_rd
    function automatic tsw_state_s cm_wr(input tsw_state_s s, input logic [2:0] ms,
                                         input logic [4:0] st, input logic [6:0] ch,
                                         input logic [15:0] d);
        tsw_state_s r;
        r = s;
        if (ms == tsw_pkg::TSW_MS_LOC_LO) begin
            r.loc_lo[{st[LSW-1:0], ch[LCW-1:0]}] = d;
        end else if (ms == tsw_pkg::TSW_MS_LOC_HI) begin
            r.loc_hi[{st[LSW-1:0], ch[LCW-1:0]}] = d;
        end else if (ms == tsw_pkg::TSW_MS_BP_CM) begin
            r.bp_cm[{st[BSW-1:0], ch[BCW-1:0]}] = d;
        end
        return r;
    endfunction : cm_wr
    logic bus_go;
    logic ab_en;
    logic [2:0] msel;
    logic [3:0] reg_off;
    logic [15:0] ab_word;
    logic [15:0] bp_word;
    logic [15:0] loc_lo_word;
    logic [15:0] loc_hi_word;
    assign bus_go = !cpu_cs_n && !cpu_ds_n;
    assign ab_en = q.ctrl[`TSW_CTRL_AB_BIT];
    assign msel = q.ctrl[`TSW_CTRL_MS_HI:`TSW_CTRL_MS_LO];
    assign reg_off = cpu_addr[3:0];
    assign ab_word = cm_rd(q, msel, q.ab_addr[11:7], q.ab_addr[6:0]);
    // One location per output channel of each stream
    assign bp_word = q.bp_cm[{bp_out_stream[BSW-1:0], bp_out_chan[BCW-1:0]}];
    assign loc_lo_word = q.loc_lo[{loc_out_stream[LSW-1:0], loc_out_chan[LCW-1:0]}];
    assign loc_hi_word = q.loc_hi[{loc_out_stream[LSW-1:0], loc_out_chan[LCW-1:0]}];
    // ----------------------------------------
    // Bus access, buffered read engine
    // ----------------------------------------
    always_comb begin
        n = q;
        n.subrate = loc_hi_word[1:0];
        case (q.bus)
            tsw_pkg::TSW_BUS_IDLE: begin
                if (bus_go) begin
                    n.bus = tsw_pkg::TSW_BUS_ACK;
                    n.rdata = 16'h0000;
                    if (cpu_addr[`TSW_ADDR_MEM_BIT]) begin
                        if (cpu_rd) begin
                            n.rdata = cm_rd(q, msel, q.ctrl[4:0], cpu_addr[6:0]);
                        end else begin
                            n = cm_wr(n, msel, q.ctrl[4:0], cpu_addr[6:0], cpu_wdata);
                        end
                    end else if (reg_off == `TSW_OFF_CTRL) begin
                        if (cpu_rd) begin
                            n.rdata = q.ctrl;
                        end else begin
                            n.ctrl = cpu_wdata & `TSW_CTRL_MASK;
                        end
                    end else if (reg_off == `TSW_OFF_DMS) begin
                        if (cpu_rd) begin
                            n.rdata = q.device_mode_select;
                        end else begin
                            n.device_mode_select = cpu_wdata & `TSW_DMS_MASK;
                        end
                    end else if (reg_off == `TSW_OFF_ABR) begin
                        if (cpu_rd) begin
                            n.rdata = ab_en ? {q.rs, q.cda, 2'b00, q.ab_addr} : 16'h0000;
                        end else if (ab_en) begin
                            n.ab_addr = cpu_wdata[11:0];
                            n.cda = 1'b0;
                            n.rs = cpu_wdata[`TSW_ABR_RS_BIT];
                            n.lat = 4'h0;
                        end
                    end else if (reg_off == `TSW_OFF_DRR) begin
                        if (cpu_rd && ab_en) begin
                            n.rdata = q.data_read_reg;
                        end
                    end else if (reg_off == `TSW_OFF_DWR) begin
                        if (!cpu_rd && ab_en) begin
                            n = cm_wr(n, msel, q.ab_addr[11:7], q.ab_addr[6:0], cpu_wdata);
                        end
                    end
                end
            end
            tsw_pkg::TSW_BUS_ACK: begin
                if (!bus_go) begin
                    n.bus = tsw_pkg::TSW_BUS_IDLE;
                end
            end
            default: begin
                n.bus = tsw_pkg::TSW_BUS_IDLE;
            end
        endcase
        // Completion overrides a clear written in the same cycle
        if (q.rs) begin
            if (q.lat == 4'(READ_LAT - 1)) begin
                n.data_read_reg = ab_word;
                n.cda = 1'b1;
                n.rs = 1'b0;
                n.lat = 4'h0;
            end else begin
                n.lat = q.lat + 4'h1;
            end
        end
        // Disabling the buffer abandons a read in flight, unless it completes in that same cycle
        if (!n.ctrl[`TSW_CTRL_AB_BIT]) begin
            n.rs = 1'b0;
            n.lat = 4'h0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.bus <= tsw_pkg::TSW_BUS_IDLE;
            q.ctrl <= `TSW_RESET_VALUE;
            q.device_mode_select <= `TSW_RESET_VALUE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    assign local_mode_field = tsw_pkg::tsw_loc_mode_e'(q.device_mode_select[4:3]);
    assign local_mode_valid = (q.device_mode_select[4:3] != 2'h3);
    // Code 101 is the 8M CT bus, 111 unused
    assign backplane_mode_field = tsw_pkg::tsw_bp_mode_e'(q.device_mode_select[2:0]);
    assign backplane_mode_valid = (q.device_mode_select[2:0] != 3'h7);
    assign subrate_en = (q.device_mode_select[4:3] == 2'h1);
    assign subrate_bit_position = subrate_en ? q.subrate : 2'b00;
    assign addr_buffer_enable = ab_en;
    assign cpu_rdata = q.rdata;

    // ----------------------------------------
    // Per-channel decoders and acknowledge pin
    // ----------------------------------------
    tsw_cm_dec #(
        .MSG_BIT(`TSW_BP_MSG_BIT),
        .DLY_BIT(`TSW_BP_DLY_BIT),
        .SIDE_BIT(`TSW_BP_DLY_BIT)
    ) u_bp_dec (
        .clock(clock),
        .rst_n(rst_n),
        .word(bp_word),
        .msg_en(bp_msg_en),
        .msg_byte(bp_msg_byte),
        .src_stream(bp_src_stream),
        .src_chan(bp_src_chan),
        .const_delay(bp_const_delay),
        .src_side()
    );
    tsw_cm_dec #(
        .MSG_BIT(`TSW_LOC_MSG_BIT),
        .DLY_BIT(`TSW_LOC_DLY_BIT),
        .SIDE_BIT(`TSW_LOC_SIDE_BIT)
    ) u_loc_dec (
        .clock(clock),
        .rst_n(rst_n),
        .word(loc_lo_word),
        .msg_en(loc_msg_en),
        .msg_byte(loc_msg_byte),
        .src_stream(loc_src_stream),
        .src_chan(loc_src_chan),
        .const_delay(loc_const_delay),
        .src_side(loc_src_backplane)
    );
    tsw_ack_drv u_ack (
        .clock(clock),
        .rst_n(rst_n),
        .ack_req(q.bus == tsw_pkg::TSW_BUS_ACK && bus_go),
        .ack_pin_i(transfer_ack_n_i),
        .transfer_ack_n_o(transfer_ack_n_o),
        .transfer_ack_oe(transfer_ack_oe)
    );
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_rs_completes;
        @(posedge clock) disable iff (!rst_n)
        $rose(q.rs) |-> ##[1:8] !q.rs;
    endproperty
    a_rs_completes: assert property (p_rs_completes)
        else $error("Buffered read never completed");
    property p_cda_rise;
        @(posedge clock) disable iff (!rst_n)
        $rose(q.cda) |-> !q.rs && $past(q.rs) && q.data_read_reg == $past(ab_word);
    endproperty
    a_cda_rise: assert property (p_cda_rise)
        else $error("Done flag rose without read completion");
    property p_ab_off_drr;
        @(posedge clock) disable iff (!rst_n)
        q.bus == tsw_pkg::TSW_BUS_IDLE && bus_go && cpu_rd && !ab_en
            && !cpu_addr[`TSW_ADDR_MEM_BIT] && reg_off == `TSW_OFF_DRR
            |=> cpu_rdata == 16'h0000;
    endproperty
    a_ab_off_drr: assert property (p_ab_off_drr)
        else $error("Data read register visible while buffer disabled");
    property p_subrate;
        @(posedge clock) disable iff (!rst_n)
        subrate_en == (local_mode_field == tsw_pkg::TSW_LOC_2M_SUB);
    endproperty
    a_subrate: assert property (p_subrate)
        else $error("Sub-rate enable does not follow local mode");
    property p_bp_ct8;
        @(posedge clock) disable iff (!rst_n)
        q.device_mode_select[2:0] == 3'h5 |-> backplane_mode_field == tsw_pkg::TSW_BP_8M_CT
            && backplane_mode_valid;
    endproperty
    a_bp_ct8: assert property (p_bp_ct8)
        else $error("Backplane code 101 not taken as 8M CT bus");
    property p_subrate_pos;
        @(posedge clock) disable iff (!rst_n)
        subrate_en && $stable(q.device_mode_select) |-> subrate_bit_position == $past(loc_hi_word[1:0]);
    endproperty
    a_subrate_pos: assert property (p_subrate_pos)
        else $error("Sub-rate position not from local high word");
endmodule : tsw_conn_ctrl

/* pkg/tsw_params.svh */
// Offsets, field positions, reset values and timing of the switch control block
`ifndef TSW_PARAMS_SVH
`define TSW_PARAMS_SVH
`define TSW_OFF_CTRL 4'h0
`define TSW_OFF_DMS 4'h1
`define TSW_OFF_ABR 4'h3
`define TSW_OFF_DRR 4'h4
`define TSW_OFF_DWR 4'h5
`define TSW_ADDR_MEM_BIT 11
`define TSW_CTRL_AB_BIT 10
`define TSW_CTRL_MS_HI 7
`define TSW_CTRL_MS_LO 5
`define TSW_CTRL_MASK 16'h07ff
`define TSW_DMS_MASK 16'h001f
`define TSW_ABR_RS_BIT 15
`define TSW_ABR_CDA_BIT 14
`define TSW_BP_MSG_BIT 13
`define TSW_BP_DLY_BIT 12
`define TSW_LOC_MSG_BIT 14
`define TSW_LOC_DLY_BIT 13
`define TSW_LOC_SIDE_BIT 12
`define TSW_RESET_VALUE 16'h0000
`define TSW_READ_LAT 3
`define TSW_CLK_NS 10
`define TSW_ACK_HOLD_NS 15
`endif

/* pkg/tsw_pkg.sv */
// Types shared by the switch control block
package tsw_pkg;
    typedef enum logic [1:0] {
        TSW_LOC_2M_STD = 2'h0,
        TSW_LOC_2M_SUB = 2'h1,
        TSW_LOC_8M_STD = 2'h2,
        TSW_LOC_RSVD = 2'h3
    } tsw_loc_mode_e;
    typedef enum logic [2:0] {
        TSW_BP_2M_SER = 3'h0,
        TSW_BP_2M_CT = 3'h1,
        TSW_BP_4M_SER = 3'h2,
        TSW_BP_4M_CT = 3'h3,
        TSW_BP_8M_SER = 3'h4,
        TSW_BP_8M_CT = 3'h5,
        TSW_BP_HMVIP = 3'h6,
        TSW_BP_RSVD = 3'h7
    } tsw_bp_mode_e;
    typedef enum logic [2:0] {
        TSW_MS_LOC_LO = 3'h0,
        TSW_MS_LOC_HI = 3'h1,
        TSW_MS_BP_CM = 3'h2,
        TSW_MS_BP_DM = 3'h4
    } tsw_msel_e;
    typedef enum logic [1:0] {
        TSW_BUS_IDLE = 2'b01,
        TSW_BUS_ACK = 2'b10
    } tsw_bus_e;
    typedef enum logic [2:0] {
        TSW_ACK_REL = 3'b001,
        TSW_ACK_LOW = 3'b010,
        TSW_ACK_HIGH = 3'b100
    } tsw_ack_e;
endpackage : tsw_pkg

/* verification/tsw_conn_ctrl_tb.sv */
// Self-checking testbench of the switch connection control
`timescale 1ns/1ps
`include "tsw_params.svh"
module tsw_conn_ctrl_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_cs_n, cpu_ds_n, cpu_rd, transfer_ack_n_o, transfer_ack_oe;
    logic [11:0] cpu_addr;
    logic [15:0] cpu_wdata, cpu_rdata, q, w;
    logic [4:0] bp_out_stream = 5'h00, loc_out_stream = 5'h00, s;
    logic [6:0] bp_out_chan = 7'h00, loc_out_chan = 7'h00, c;
    tsw_pkg::tsw_loc_mode_e local_mode_field;
    tsw_pkg::tsw_bp_mode_e backplane_mode_field;
    logic local_mode_valid, backplane_mode_valid, subrate_en, addr_buffer_enable;
    logic bp_msg_en, bp_const_delay, loc_msg_en, loc_const_delay, loc_src_backplane;
    logic [7:0] bp_msg_byte, loc_msg_byte;
    logic [4:0] bp_src_stream, loc_src_stream;
    logic [6:0] bp_src_chan, loc_src_chan;
    logic [1:0] subrate_bit_position;
    int errors = 0;
    int cmp_count = 0;
    // Ack wire with pull-up
    wire ack_w = transfer_ack_oe ? transfer_ack_n_o : 1'b1;
    always #5 clock = ~clock;
    tsw_conn_ctrl tsw_conn_ctrl_i (.clock, .rst_n, .cpu_cs_n, .cpu_ds_n, .cpu_rd, .cpu_addr,
        .cpu_wdata, .cpu_rdata, .transfer_ack_n_o, .transfer_ack_oe,
        .transfer_ack_n_i(ack_w), .bp_out_stream, .bp_out_chan, .loc_out_stream,
        .loc_out_chan, .local_mode_field, .backplane_mode_field, .local_mode_valid,
        .backplane_mode_valid, .subrate_en, .addr_buffer_enable, .bp_msg_en, .bp_msg_byte,
        .bp_src_stream, .bp_src_chan, .bp_const_delay, .loc_msg_en, .loc_msg_byte,
        .loc_src_stream, .loc_src_chan, .loc_const_delay, .loc_src_backplane,
        .subrate_bit_position);
    tsw_host tsw_host_i (.clock, .cpu_cs_n, .cpu_ds_n, .cpu_rd, .cpu_addr, .cpu_wdata,
        .cpu_rdata, .ack_n(ack_w));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic acc(input logic rd, input logic [11:0] a, input logic [15:0] d);
        logic ok;
        tsw_host_i.access(rd, a, d, q, ok);
        chk("ack_low", 32'(ok), 32'h1);
        chk("ack_released", 32'(transfer_ack_oe), 32'h0);
    endtask : acc
    function automatic logic [21:0] dec(input logic [15:0] x, input int mb, input int db);
        logic m;
        m = x[mb];
        return {m, m ? x[7:0] : 8'h00, m ? 5'h00 : x[11:7], m ? 7'h00 : x[6:0], x[db]};
    endfunction : dec
    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hb9ea));
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        acc(1'b1, 12'(`TSW_OFF_DMS), 16'h0000);
        chk("dms_reset", 32'(q), 32'h0);
        for (int m = 0; m < 32; m++) begin
            acc(1'b0, 12'(`TSW_OFF_DMS), 16'(m));
            chk("local_mode", 32'(local_mode_field), 32'(m[4:3]));
            chk("bp_mode", 32'(backplane_mode_field), 32'(m[2:0]));
            chk("valids", 32'({local_mode_valid, backplane_mode_valid, subrate_en}),
                32'({m[4:3] != 2'h3, m[2:0] != 3'h7, m[4:3] == 2'h1}));
        end
        acc(1'b0, 12'(`TSW_OFF_DMS), 16'h0008);
        for (int i = 0; i < 12; i++) begin
            s = 5'($urandom_range(15, 0));
            c = 7'($urandom_range(31, 0));
            w = 16'($urandom);
            if (i < 4) {w[14], w[13]} = 2'(i);
            acc(1'b0, 12'(`TSW_OFF_CTRL), {11'h022, s});
            chk("ab_on", 32'(addr_buffer_enable), 32'h1);
            acc(1'b0, {5'h10, c}, w);
            acc(1'b0, 12'(`TSW_OFF_ABR), {4'h8, s, c});
            acc(1'b1, 12'(`TSW_OFF_ABR), 16'h0000);
            chk("abr_done", 32'(q[15:14]), 32'h1);
            acc(1'b1, 12'(`TSW_OFF_DRR), 16'h0000);
            chk("drr", 32'(q), 32'(w));
            acc(1'b0, 12'(`TSW_OFF_CTRL), {11'h000, s});
            chk("ab_off", 32'(addr_buffer_enable), 32'h0);
            acc(1'b1, 12'(`TSW_OFF_DRR), 16'h0000);
            chk("drr_off", 32'(q), 32'h0);
            acc(1'b0, {5'h10, c}, w);
            acc(1'b1, {5'h10, c}, 16'h0000);
            chk("win_rd", 32'(q), 32'(w));
            acc(1'b0, 12'(`TSW_OFF_CTRL), {11'h001, s});
            acc(1'b0, {5'h10, c}, w);
            @(negedge clock);
            bp_out_stream = s;
            bp_out_chan = c;
            loc_out_stream = s;
            loc_out_chan = c;
            repeat (3) @(negedge clock);
            chk("bp_dec", 32'({bp_msg_en, bp_msg_byte, bp_src_stream, bp_src_chan,
                bp_const_delay}), 32'(dec(w, 13, 12)));
            chk("loc_dec", 32'({loc_msg_en, loc_msg_byte, loc_src_stream, loc_src_chan,
                loc_const_delay}), 32'(dec(w, 14, 13)));
            chk("loc_side", 32'(loc_src_backplane), 32'(w[12]));
            chk("subrate_pos", 32'(subrate_bit_position), 32'(w[1:0]));
        end
        // Buffered write, done flag cleared by a new address, mid-run reset
        w = 16'($urandom);
        acc(1'b0, 12'(`TSW_OFF_CTRL), 16'h0443);
        acc(1'b0, 12'(`TSW_OFF_ABR), 16'h0185);
        acc(1'b0, 12'(`TSW_OFF_DWR), w);
        acc(1'b1, 12'(`TSW_OFF_ABR), 16'h0000);
        chk("abr_clear", 32'(q), 32'h0185);
        acc(1'b1, 12'h805, 16'h0000);
        chk("dwr", 32'(q), 32'(w));
        acc(1'b1, 12'(`TSW_OFF_CTRL), 16'h0000);
        chk("ctrl_rd", 32'(q), 32'h0443);
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        acc(1'b1, 12'(`TSW_OFF_CTRL), 16'h0000);
        chk("ctrl_reset", 32'(q), 32'h0);
        chk("ab_reset", 32'(addr_buffer_enable), 32'h0);
        tally_and_finish();
    end
endmodule : tsw_conn_ctrl_tb

/* verification/tsw_host.sv */
// Host processor model on the register bus
`timescale 1ns/1ps
module tsw_host (
    input wire logic clock,
    output logic cpu_cs_n,
    output logic cpu_ds_n,
    output logic cpu_rd,
    output logic [11:0] cpu_addr,
    output logic [15:0] cpu_wdata,
    input wire logic [15:0] cpu_rdata,
    input wire logic ack_n
);
    initial begin
        cpu_cs_n = 1'b1;
        cpu_ds_n = 1'b1;
        cpu_rd = 1'b0;
        cpu_addr = 12'h000;
        cpu_wdata = 16'h0000;
    end
    // One bus cycle: strobe until acknowledge, then release
    task automatic access(input logic rd, input logic [11:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        @(negedge clock);
        cpu_cs_n = 1'b0;
        cpu_ds_n = 1'b0;
        cpu_rd = rd;
        cpu_addr = a;
        cpu_wdata = d;
        repeat (8) begin
            @(posedge clock);
            if (ack_n === 1'b0) break;
        end
        ok = (ack_n === 1'b0);
        q = cpu_rdata;
        @(negedge clock);
        cpu_cs_n = 1'b1;
        cpu_ds_n = 1'b1;
        cpu_rd = ~rd;
        cpu_addr = ~a;
        cpu_wdata = ~d;
        repeat (3) @(posedge clock);
    endtask : access
endmodule : tsw_host
